// [design/occ_pkg.sv]
// Purpose: Shared constants for the output compare channel block
// Assumes: Single peripheral clock, synchronous active-high reset
// Notes: Control word layout follows the compare control register
package occ_pkg;
    // ****************************************
    // Control word fields
    // ****************************************
    localparam int CTRL_W = 16;
    localparam int BIT_ON = 15;
    localparam int BIT_STOP_IN_IDLE = 13;
    localparam int BIT_WIDE = 5;
    localparam int BIT_FLT = 4;
    localparam int BIT_TSEL = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_PWM_NOFLT = 16'h0006;
    localparam logic [15:0] CTRL_ON_WIDE = 16'h8020;
    // ****************************************
    // Mode encodings
    // ****************************************
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_HIGH = 3'h1;
    localparam logic [2:0] MODE_LOW = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_PULSE = 3'h4;
    localparam logic [2:0] MODE_PULSES = 3'h5;
    localparam logic [2:0] MODE_PWM = 3'h6;
    localparam logic [2:0] MODE_PWM_FLT = 3'h7;
    // ****************************************
    // Interrupt priority, fault input split, data widths and power states
    // ****************************************
    localparam int PRIO_W = 3;
    localparam int SUB_W = 2;
    localparam logic [2:0] PRIO_NONE = 3'h0;
    localparam int FAULT_A_LAST_CH = 4;
    localparam int DATA_W = 32;
    localparam int NARROW_W = 16;
    typedef enum logic [1:0] {OCC_RUN, OCC_HALT} occ_power_t;
endpackage

// [design/occ_channel.sv]
// Purpose: One output compare channel with flag, pin ownership, fault and power
// Assumes: Time base and interrupt controller are outside; CH_NUM picks fault input
// Notes: Fault output disable acts combinationally from the pin and is then held by the registered fault status
//
// Behaviour
// - Own flag and own enable per channel
// - Match sets flag regardless of enable
// - Request only while enable bit set
// - Three-bit priority group, zero never requests
// - Two-bit subpriority exported for arbitration
// - Equal ties resolved by lower vector number
// - Vector number equals natural order number
// - Enabled unit owns pin, else latch/direction
// - Fault A serves channels 1-4, B serves 5
// - Sleep holds last pin level and halts
// - Sleep fault disables output, sets status, wakes
// - Stop-in-idle makes idle behave like sleep
// - Idle runs only with timebase enabled, idle-capable
// - Fault inputs keep control in sleep/idle
// - Idle fault disables output, sets status, wakes
// - Debug keeps fault path active
// - PWM modes raise no compare interrupt
// - 0x0006 is PWM no fault; 0x8020 wide on
// - Mode 111 low fault tri-states output unclocked
// - Fault status clears after removal and mode rewrite
// - Duty copied from secondary only at period match
module occ_channel
    import occ_pkg::*;
#(
    parameter int CH_NUM = 1,
    parameter logic [5:0] VECTOR_NUM = 6'h06
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control register write
    input wire logic ctrl_we,
    input wire logic [occ_pkg::CTRL_W-1:0] ctrl_wdata,
    output logic [occ_pkg::CTRL_W-1:0] compare_control_reg,
    // Compare registers
    input wire logic primary_we,
    input wire logic [occ_pkg::DATA_W-1:0] primary_wdata,
    input wire logic secondary_we,
    input wire logic [occ_pkg::DATA_W-1:0] secondary_wdata,
    output logic [occ_pkg::DATA_W-1:0] primary_compare_reg,
    output logic [occ_pkg::DATA_W-1:0] secondary_compare_reg,
    // Time base
    input wire logic [occ_pkg::DATA_W-1:0] timer_count_reg,
    input wire logic [occ_pkg::DATA_W-1:0] timer_period_reg,
    input wire logic timer_enabled,
    input wire logic timer_runs_in_idle,
    // Interrupt control
    input wire logic compare_irq_enable,
    input wire logic [occ_pkg::PRIO_W-1:0] compare_irq_priority,
    input wire logic [occ_pkg::SUB_W-1:0] compare_irq_subpriority,
    input wire logic flag_clear,
    output logic compare_irq_flag,
    output logic irq_request,
    output logic [occ_pkg::PRIO_W-1:0] irq_group,
    output logic [occ_pkg::SUB_W-1:0] irq_sub,
    output logic [5:0] irq_vector,
    output logic wake_request,
    // Power state
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic debug_mode,
    // Pins
    input wire logic fault_input_a,
    input wire logic fault_input_b,
    input wire logic pin_output_latch,
    input wire logic pin_direction_bit,
    output logic compare_output_pin,
    output logic compare_output_oe
);
    import occ_pkg::*;

    // Only five channels exist, and the fault input choice depends on it
    if (CH_NUM < 1 || CH_NUM > 5) begin : g_bad_ch
        $error("CH_NUM must be 1 to 5");
    end

    // ****************************************
    // Control fields
    // ****************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [DATA_W-1:0] pri_q, sec_q;
    logic level_q, flag_q, fault_q;
    logic flt_s1_q, flt_s2_q, mode_rewrite_q;
    wire logic unit_on = ctrl_q[BIT_ON];
    wire logic [2:0] mode = ctrl_q[MODE_LSB +: MODE_W];
    wire logic wide = ctrl_q[BIT_WIDE];
    wire logic is_pwm = (mode == MODE_PWM) || (mode == MODE_PWM_FLT);
    wire logic flt_mode = unit_on && (mode == MODE_PWM_FLT);

    // Fault A for channels 1-4, B for channel 5
    wire logic fault_raw_n = (CH_NUM <= FAULT_A_LAST_CH) ? fault_input_a
                                                           : fault_input_b;

    // ****************************************
    // Power state
    // ****************************************
    // Idle with stop-in-idle set is treated as sleep; idle otherwise needs the timer
    wire logic stop_idle = idle_mode && ctrl_q[BIT_STOP_IN_IDLE];
    wire logic idle_ok = !idle_mode || (timer_enabled && timer_runs_in_idle);
    occ_power_t power;
    assign power = (sleep_mode || stop_idle || !idle_ok) ? OCC_HALT : OCC_RUN;
    wire logic running = unit_on && (power == OCC_RUN);

    // ****************************************
    // Compare logic
    // ****************************************
    function automatic logic [DATA_W-1:0] fit(input logic [DATA_W-1:0] v, input logic w);
        fit = w ? v : {{(DATA_W-NARROW_W){1'b0}}, v[NARROW_W-1:0]};
    endfunction

    wire logic [DATA_W-1:0] tmr = fit(timer_count_reg, wide);
    wire logic [DATA_W-1:0] per = fit(timer_period_reg, wide);
    wire logic hit_pri = (tmr == fit(pri_q, wide));
    wire logic hit_sec = (tmr == fit(sec_q, wide));
    wire logic period_hit = (tmr == per);
    logic level_d;
    logic match_evt;
    always_comb begin
        level_d = level_q;
        match_evt = 1'b0;
        case (mode)
            MODE_HIGH: begin
                if (hit_pri) begin
                    level_d = 1'b1;
                    match_evt = 1'b1;
                end
            end
            MODE_LOW: begin
                if (hit_pri) begin
                    level_d = 1'b0;
                    match_evt = 1'b1;
                end
            end
            MODE_TOGGLE: begin
                if (hit_pri) begin
                    level_d = !level_q;
                    match_evt = 1'b1;
                end
            end
            MODE_PULSE, MODE_PULSES: begin
                if (hit_pri) begin
                    level_d = 1'b1;
                end
                if (hit_sec) begin
                    level_d = 1'b0;
                    match_evt = 1'b1;
                end
            end
            MODE_PWM, MODE_PWM_FLT: begin
                // Duty 0 stays low, duty above period stays high
                if (period_hit) begin
                    level_d = (sec_q != '0);
                end else if (hit_pri) begin
                    level_d = 1'b0;
                end
            end
            default: begin
                level_d = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Fault path
    // ****************************************
    // The tri-state acts directly from the pin so it works without a clock
    wire logic fault_async = flt_mode && !fault_raw_n;
    wire logic fault_seen = flt_mode && !flt_s2_q;
    wire logic fault_set = fault_seen && !fault_q;
    // Clear only after the pin is back high and the mode field was rewritten
    wire logic fault_clr = fault_q && mode_rewrite_q && flt_s2_q;
    wire logic evt_set = (running && match_evt && !is_pwm) || fault_set;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flt_s1_q <= 1'b1;
            flt_s2_q <= 1'b1;
        end else begin
            flt_s1_q <= fault_raw_n;
            flt_s2_q <= flt_s1_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (fault_clr || !flt_mode) begin
            fault_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_rewrite_q <= 1'b0;
        end else if (ctrl_we) begin
            mode_rewrite_q <= fault_q;
        end else if (fault_set) begin
            mode_rewrite_q <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else if (evt_set) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    wire logic [CTRL_W-1:0] ctrl_wr = ctrl_wdata & ~(CTRL_W'(1) << BIT_FLT);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl_q <= ctrl_wr;
        end
    end

    // Duty register follows writes only while the unit is off or not in a PWM mode
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pri_q <= '0;
        end else if (is_pwm && unit_on) begin
            if (running && period_hit) begin
                pri_q <= sec_q;
            end
        end else if (primary_we) begin
            pri_q <= primary_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sec_q <= '0;
        end else if (secondary_we) begin
            sec_q <= secondary_wdata;
        end
    end

    // Level only moves while running or when the unit is off (cleared to 0), so sleep freezes the pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (!unit_on) begin
            level_q <= 1'b0;
        end else if (running) begin
            level_q <= level_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign compare_control_reg = {ctrl_q[CTRL_W-1:BIT_FLT+1], fault_q, ctrl_q[BIT_FLT-1:0]};
    assign primary_compare_reg = pri_q;
    assign secondary_compare_reg = sec_q;
    assign compare_irq_flag = flag_q;
    assign irq_request = flag_q && compare_irq_enable && (compare_irq_priority != PRIO_NONE);
    assign irq_group = compare_irq_priority;
    assign irq_sub = compare_irq_subpriority;
    assign irq_vector = VECTOR_NUM;
    assign wake_request = irq_request && (power == OCC_HALT);
    assign compare_output_pin = unit_on ? level_q : pin_output_latch;
    assign compare_output_oe = unit_on ? !(fault_async || fault_q) : !pin_direction_bit;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_fault_low;
        flt_mode && !flt_s2_q && !fault_q;
    endsequence

    a_fault_sets_status: assert property (@(posedge clock) disable iff (sys_rst)
        s_fault_low |=> fault_q && flag_q) else $error("fault not recorded");
    a_flag_hold_clear: assert property (@(posedge clock) disable iff (sys_rst)
        flag_q && !flag_clear |=> flag_q) else $error("flag cleared by itself");
    a_irq_gated_enable: assert property (@(posedge clock) disable iff (sys_rst)
        !compare_irq_enable |-> !irq_request) else $error("request while masked");
    a_prio_zero_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        compare_irq_priority == PRIO_NONE |-> !irq_request) else $error("prio 0 request");
    a_fault_tristate: assert property (@(posedge clock) disable iff (sys_rst)
        flt_mode && !fault_raw_n |-> !compare_output_oe) else $error("fault not tristated");
    a_sleep_holds_pin: assert property (@(posedge clock) disable iff (sys_rst)
        unit_on && sleep_mode && $past(unit_on && sleep_mode) && !ctrl_we
        |-> $stable(level_q)) else $error("pin moved in sleep");
    a_pwm_no_match_irq: assert property (@(posedge clock) disable iff (sys_rst)
        is_pwm && !fault_set && !flag_q |=> !flag_q) else $error("pwm set flag");
    a_duty_reload: assert property (@(posedge clock) disable iff (sys_rst)
        unit_on && is_pwm && running && period_hit && !ctrl_we
        |=> pri_q == $past(sec_q)) else $error("duty not reloaded");
    a_pin_handback: assert property (@(posedge clock) disable iff (sys_rst)
        !unit_on |-> compare_output_pin == pin_output_latch) else $error("pin not returned");

    // ****************************************
    // Further checks
    // ****************************************
    // Status drops once the pin is back high and the mode was rewritten, or as soon as the unit is off or out of mode 111
    sequence s_fault_gone;
        fault_q && mode_rewrite_q && flt_s2_q;
    endsequence

    sequence s_fault_active;
        fault_q && flt_mode && !flt_s2_q;
    endsequence

    a_fault_clears: assert property (@(posedge clock) disable iff (sys_rst)
        s_fault_gone |=> !fault_q) else $error("fault status stuck");
    a_fault_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        s_fault_active |=> fault_q) else $error("fault status dropped");
    a_debug_fault_path: assert property (@(posedge clock) disable iff (sys_rst)
        debug_mode && flt_mode && !fault_raw_n |-> !compare_output_oe)
        else $error("debug fault not tristated");
    a_req_needs_flag: assert property (@(posedge clock) disable iff (sys_rst)
        irq_request |-> compare_irq_flag) else $error("request without flag");
    a_wake_only_halted: assert property (@(posedge clock) disable iff (sys_rst)
        wake_request |-> irq_request && (sleep_mode || idle_mode))
        else $error("wake while awake");
    a_oe_handback: assert property (@(posedge clock) disable iff (sys_rst)
        !unit_on |-> compare_output_oe == !pin_direction_bit)
        else $error("direction not returned");
    a_off_level_low: assert property (@(posedge clock) disable iff (sys_rst)
        !unit_on |=> !level_q) else $error("level kept while off");
    a_vector_fixed: assert property (@(posedge clock) disable iff (sys_rst)
        irq_vector == VECTOR_NUM) else $error("vector moved");
endmodule

// [sim/occ_timer_model.sv]
// Purpose: Time base that feeds the compare channel
// Assumes: Counts one step each clock while run is high
// Notes: Holds its count while stopped, so a stopped timer can keep matching
module occ_timer_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic [31:0] period,
    // Time base
    output logic [31:0] count
);
    timeunit 1ns;
    timeprecision 1ps;
    // A period value of N gives N+1 counts before the wrap
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= 32'h0;
        end else if (run) begin
            count <= (count >= period) ? 32'h0 : count + 32'h1;
        end
    end
endmodule

// [sim/occ_channel_tb.sv]
// Purpose: Self-checking bench for one compare channel
// Assumes: Channel 1, so the first fault input is the live one
// Notes: Inputs change on the falling edge only
module occ_channel_tb import occ_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, ctrl_we = 0, primary_we = 0, secondary_we = 0;
    logic flag_clear = 0, ie = 0, slp = 0, idl = 0, dbg = 0, flt_a = 1, flt_b = 1;
    logic lat = 0, dir = 1, trun = 0, tidle = 0;
    logic [15:0] wd = 16'h0;
    logic [31:0] pwd = 32'h0, swd = 32'h0, per = 32'h9;
    logic [2:0] prio = 3'h0;
    logic [1:0] sub = 2'h0;
    logic [15:0] ctrl;
    logic [31:0] pri, sec, cnt;
    logic flag, req, wake, pin, oe;
    logic [2:0] grp;
    logic [1:0] isub;
    logic [5:0] vec;
    int bad_count = 0, total_checks = 0, cyc = 0, seed = 32'h48a0, i;

    always #2 clock = ~clock;

    occ_timer_model i_occ_timer_model (.clock(clock), .sys_rst(sys_rst), .run(trun),
        .period(per), .count(cnt));

    occ_channel #(.CH_NUM(1), .VECTOR_NUM(6'h0b)) i_occ_channel (.clock(clock),
        .sys_rst(sys_rst), .ctrl_we(ctrl_we), .ctrl_wdata(wd), .compare_control_reg(ctrl),
        .primary_we(primary_we), .primary_wdata(pwd), .secondary_we(secondary_we),
        .secondary_wdata(swd), .primary_compare_reg(pri), .secondary_compare_reg(sec),
        .timer_count_reg(cnt), .timer_period_reg(per), .timer_enabled(trun),
        .timer_runs_in_idle(tidle), .compare_irq_enable(ie), .compare_irq_priority(prio),
        .compare_irq_subpriority(sub), .flag_clear(flag_clear), .compare_irq_flag(flag),
        .irq_request(req), .irq_group(grp), .irq_sub(isub), .irq_vector(vec),
        .wake_request(wake), .sleep_mode(slp), .idle_mode(idl), .debug_mode(dbg),
        .fault_input_a(flt_a), .fault_input_b(flt_b), .pin_output_latch(lat),
        .pin_direction_bit(dir), .compare_output_pin(pin), .compare_output_oe(oe));

    // ****************************************
    // Helpers
    // ****************************************
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out;
        end
    end

    task chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    task chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task cyc_n(input int n);
        repeat (n) @(negedge clock);
    endtask

    // One idle cycle after each write, so back-to-back calls never retoggle the strobe
    task wctl(input logic [15:0] v);
        wd = v;
        ctrl_we = 1;
        cyc_n(1);
        ctrl_we = 0;
        cyc_n(1);
    endtask

    task pulse_clear;
        flag_clear = 1;
        cyc_n(1);
        flag_clear = 0;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        cyc_n(12);
        sys_rst = 0;
        chk_val("ctrl", 32'h0, 32'(ctrl));
        chk_bit("oe off", 1'b0, oe);
        lat = 1;
        dir = 0;
        cyc_n(1);
        chk_bit("pin latch", 1'b1, pin);
        chk_bit("oe latch", 1'b1, oe);
        chk_val("vector", 32'h0b, 32'(vec));
        $display("test reset done");
        dir = 1;
        pwd = 32'h5;
        primary_we = 1;
        cyc_n(1);
        primary_we = 0;
        trun = 1;
        wctl(16'h8001);
        chk_bit("oe on", 1'b1, oe);
        for (i = 0; i < 40 && flag !== 1'b1; i++) cyc_n(1);
        chk_bit("flag", 1'b1, flag);
        chk_bit("pin high", 1'b1, pin);
        chk_bit("req masked", 1'b0, req);
        ie = 1;
        cyc_n(1);
        chk_bit("req prio0", 1'b0, req);
        for (int k = 0; k < 16; k++) begin
            prio = 3'($random(seed));
            sub = 2'($random(seed));
            cyc_n(1);
            chk_bit("req", prio != 3'h0, req);
            chk_val("group", 32'(prio), 32'(grp));
            chk_val("sub", 32'(sub), 32'(isub));
        end
        chk_bit("flag sticky", 1'b1, flag);
        prio = 3'h7;
        slp = 1;
        cyc_n(1);
        chk_bit("wake sleep", 1'b1, wake);
        chk_bit("pin slept", 1'b1, pin);
        slp = 0;
        idl = 1;
        tidle = 1;
        cyc_n(1);
        chk_bit("wake idle run", 1'b0, wake);
        wctl(16'ha001);
        chk_bit("wake idle stop", 1'b1, wake);
        idl = 0;
        wctl(16'h0000);
        pulse_clear;
        chk_bit("flag clr", 1'b0, flag);
        $display("test interrupt done");
        wctl(16'h0006);
        chk_val("ctrl pwm", 32'h0006, 32'(ctrl));
        swd = 32'h3;
        secondary_we = 1;
        cyc_n(1);
        secondary_we = 0;
        chk_val("secondary", 32'h3, sec);
        // Start PWM just after a wrap so no period match hits the primary write
        for (i = 0; i < 20 && cnt !== 32'h1; i++) cyc_n(1);
        wctl(16'h8006);
        pwd = 32'h7;
        primary_we = 1;
        cyc_n(1);
        primary_we = 0;
        chk_val("primary ro", 32'h5, pri);
        for (i = 0; i < 20 && cnt !== per; i++) cyc_n(1);
        cyc_n(1);
        chk_val("duty copy", 32'h3, pri);
        cyc_n(30);
        chk_bit("pwm noflag", 1'b0, flag);
        $display("test pwm done");
        wctl(16'h8007);
        prio = 3'h5;
        dbg = 1;
        flt_b = 0;
        cyc_n(4);
        chk_bit("fault b", 1'b0, ctrl[BIT_FLT]);
        flt_b = 1;
        // The fault pin is only ever read by the channel, never driven by it
        flt_a = 0;
        #1;
        chk_bit("oe fault", 1'b0, oe);
        cyc_n(2);
        chk_bit("status sync", 1'b0, ctrl[BIT_FLT]);
        cyc_n(1);
        chk_bit("status", 1'b1, ctrl[BIT_FLT]);
        chk_bit("fault flag", 1'b1, flag);
        chk_bit("fault req", 1'b1, req);
        slp = 1;
        cyc_n(1);
        chk_bit("fault wake", 1'b1, wake);
        slp = 0;
        flt_a = 1;
        cyc_n(4);
        chk_bit("status held", 1'b1, ctrl[BIT_FLT]);
        wctl(16'h8006);
        cyc_n(1);
        chk_val("status clr", 32'h8006, 32'(ctrl));
        chk_bit("oe back", 1'b1, oe);
        $display("test fault done");
        close_out;
    end
endmodule
